/* common/cct_pkg.sv */
// cct_pkg: constants and carriers for the configurable counter-timer block
// assumes a 20 MHz pclk and an APB register port with 32-bit data
package cct_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;  // run/stop word
   localparam logic [11:0] OFS_CFG    = 12'h004;
   localparam logic [11:0] OFS_UPPER0 = 12'h008;
   localparam logic [11:0] OFS_LOWER0 = 12'h00C;
   localparam logic [11:0] OFS_PRESET0 = 12'h010;
   localparam logic [11:0] OFS_STEP0  = 12'h014;
   localparam logic [11:0] OFS_UPPER1 = 12'h018;
   localparam logic [11:0] OFS_LOWER1 = 12'h01C;
   localparam logic [11:0] OFS_PRESET1 = 12'h020;
   localparam logic [11:0] OFS_STEP1  = 12'h024;
   localparam logic [11:0] OFS_COUNT0 = 12'h028;
   localparam logic [11:0] OFS_COUNT1 = 12'h02C;
   localparam logic [11:0] OFS_LATCH0 = 12'h030;
   localparam logic [11:0] OFS_LATCH1 = 12'h034;
   localparam logic [11:0] OFS_STATUS = 12'h038;
   // control word fields
   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_STOP_BIT = 1;
   // configuration word fields
   localparam int CFG_WIDE_BIT    = 0;  // 1: one 32-bit counter
   localparam int CFG_SIGNED_BIT  = 1;
   localparam int CFG_ENABLE_BIT  = 2;  // count enable, per counter
   localparam int CFG_ENABLE1_BIT = 3;
   localparam int CFG_RING_BIT    = 4;  // 32-bit only
   localparam int CFG_STEPM_BIT   = 5;
   localparam int CFG_SP_BIT      = 6;  // stop also presets
   localparam int CFG_PS_BIT      = 7;  // preset also stops
   localparam int CFG_LOGIC_BIT   = 8;  // overall logic running
   localparam int CFG_TICK_LSB    = 12;
   localparam int CFG_TICK_W      = 3;
   localparam logic [31:0] CFG_RESET = 32'h0000_010C;
   // tick period selection
   localparam logic [2:0] TICK_25NS  = 3'h0;
   localparam logic [2:0] TICK_50NS  = 3'h1;
   localparam logic [2:0] TICK_100NS = 3'h2;
   localparam logic [2:0] TICK_1US   = 3'h3;
   localparam logic [2:0] TICK_10US  = 3'h4;
   localparam logic [2:0] TICK_100US = 3'h5;
   localparam logic [2:0] TICK_1MS   = 3'h6;
   // timing: periods in ps, clock period in ps
   localparam longint CLK_PS = 50000;
   localparam longint PER_PS [7] = '{25000, 50000, 100000, 1000000,
                                     10000000, 100000000, 1000000000};
   function automatic logic [15:0] tick_cycles(input int i);
      longint c;
      c = PER_PS[i] / CLK_PS;  // shortest time rounds down to zero
      if (c < 1) c = 1;
      return 16'(c);
   endfunction : tick_cycles
   // status fields
   localparam int ST_RUN0_BIT = 0;
   localparam int ST_RUN1_BIT = 1;
   localparam int ST_OVF_BIT  = 2;
   localparam int ST_UNF_BIT  = 3;
   // event terminals of one counter; preset, stop, run, up and down already ORs of their sources
   typedef struct packed {
      logic preset;
      logic stop;
      logic run;
      logic up;
      logic down;
      logic latch;
      logic latch_lvl;  // event input whose rising edge latches
   } cct_ev_type;
endpackage : cct_pkg

/* core/cct_top.sv */
// cct_top: two 16-bit or one 32-bit up/down counter-timer with APB registers
// assumes event inputs synchronous to pclk; lane 0 drives the 32-bit counter
`timescale 1ns/10ps
`default_nettype none
module cct_top #(
   parameter int NSRC = 2
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [NSRC-1:0]     ev_preset [2],
   input  wire logic [NSRC-1:0]     ev_stop   [2],
   input  wire logic [NSRC-1:0]     ev_run    [2],
   input  wire logic [NSRC-1:0]     ev_up     [2],
   input  wire logic [NSRC-1:0]     ev_down   [2],
   input  wire logic [1:0]          latch_ev,
   input  wire logic [1:0]          latch_lvl,
   output logic      [31:0]         count_out,
   output logic                     overflow,
   output logic                     underflow
);
   // register state
   logic [31:0] cfg_r, cfg_nxt;
   logic [31:0] upper_r [2], upper_nxt [2];
   logic [31:0] lower_r [2], lower_nxt [2];
   logic [31:0] pre_r [2], pre_nxt [2];
   logic [31:0] step_r [2], step_nxt [2];
   logic [1:0]  sw_run, sw_stop;
   // counter state
   logic [31:0] cnt_r [2], cnt_nxt [2];
   logic [31:0] lat_r [2], lat_nxt [2];
   logic [1:0]  run_r, run_nxt, pend_r, pend_nxt, lvl_r, lvl_nxt, halt_r, halt_nxt;
   logic        ovf_r, ovf_nxt, unf_r, unf_nxt;
   logic [15:0] tick_r, tick_nxt;
   logic        tick;
   logic [31:0] prdata_nxt;
   cct_pkg::cct_ev_type ev [2];

   logic wide, sgn, ring, stepm, logic_on;
   assign wide     = cfg_r[cct_pkg::CFG_WIDE_BIT];
   assign sgn      = cfg_r[cct_pkg::CFG_SIGNED_BIT];
   assign ring     = cfg_r[cct_pkg::CFG_RING_BIT] | ~wide;
   assign stepm    = cfg_r[cct_pkg::CFG_STEPM_BIT];
   assign logic_on = cfg_r[cct_pkg::CFG_LOGIC_BIT];

   logic wr, rd;
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;  // read data launched with pready

   // full-range default limits for the reset configuration (16-bit unsigned)
   localparam logic [31:0] LIM_HI16U = 32'h0000_FFFF;

   // shared tick divider
   always_comb begin
      logic [15:0] lim;
      lim = cct_pkg::tick_cycles(0);
      for (int i = 0; i < 7; i++)
         if (cfg_r[cct_pkg::CFG_TICK_LSB +: cct_pkg::CFG_TICK_W] == 3'(i))
            lim = cct_pkg::tick_cycles(i);
      tick     = (tick_r >= lim - 16'h0001);
      tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
   end

   // event gathering
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         ev[k].preset    = |ev_preset[k];
         ev[k].stop      = |ev_stop[k] | sw_stop[k];
         ev[k].run       = |ev_run[k] | sw_run[k];
         ev[k].up        = |ev_up[k];
         ev[k].down      = |ev_down[k];
         ev[k].latch     = latch_ev[k];
         ev[k].latch_lvl = latch_lvl[k];
      end
   end

   // counter next state
   always_comb begin
      logic [32:0] hi, lo, c, s, v;
      logic        act, en, up_go, dn_go;
      hi    = 33'h0_0000_0000;
      lo    = 33'h0_0000_0000;
      c     = 33'h0_0000_0000;
      s     = 33'h0_0000_0000;
      v     = 33'h0_0000_0000;
      act   = 1'b0;
      en    = 1'b0;
      up_go = 1'b0;
      dn_go = 1'b0;
      ovf_nxt = ovf_r;
      unf_nxt = unf_r;
      for (int k = 0; k < 2; k++) begin
         act = (k == 0) | ~wide;
         en  = cfg_r[cct_pkg::CFG_ENABLE_BIT + k];
         cnt_nxt[k]  = cnt_r[k];
         lat_nxt[k]  = lat_r[k];
         run_nxt[k]  = run_r[k];
         lvl_nxt[k]  = ev[k].latch_lvl;
         pend_nxt[k] = pend_r[k] | ev[k].run;
         halt_nxt[k] = halt_r[k];
         // sign-extended compare domain, 33 bits
         if (wide) begin
            c  = {sgn & cnt_r[k][31], cnt_r[k]};
            hi = {sgn & upper_r[k][31], upper_r[k]};
            lo = {sgn & lower_r[k][31], lower_r[k]};
            s  = stepm ? {1'b0, step_r[k]} : 33'h0_0000_0001;
         end else begin
            c  = {{17{sgn & cnt_r[k][15]}}, cnt_r[k][15:0]};
            hi = {{17{sgn & upper_r[k][15]}}, upper_r[k][15:0]};
            lo = {{17{sgn & lower_r[k][15]}}, lower_r[k][15:0]};
            s  = stepm ? {17'h0_0000, step_r[k][15:0]} : 33'h0_0000_0001;
         end
         // flip top bit so unsigned compare orders signed values
         c[32] = c[32] ^ sgn;
         hi[32] = hi[32] ^ sgn;
         lo[32] = lo[32] ^ sgn;
         up_go = 1'b0;
         dn_go = 1'b0;
         if (ev[k].latch | (ev[k].latch_lvl & ~lvl_r[k]))
            lat_nxt[k] = cnt_r[k];
         if (ev[k].preset) begin
            cnt_nxt[k] = pre_r[k];
            if (k == 0) begin
               ovf_nxt = 1'b0;
               unf_nxt = 1'b0;
            end
            if (cfg_r[cct_pkg::CFG_PS_BIT]) begin
               run_nxt[k]  = 1'b0;
               pend_nxt[k] = 1'b0;
               halt_nxt[k] = 1'b1;
            end
         end else if (ev[k].stop) begin
            run_nxt[k]  = 1'b0;
            halt_nxt[k] = 1'b1;
            pend_nxt[k] = 1'b0;
            if (cfg_r[cct_pkg::CFG_SP_BIT])
               cnt_nxt[k] = pre_r[k];
         end else if (pend_r[k] | ev[k].run) begin
            run_nxt[k]  = 1'b1;
            halt_nxt[k] = 1'b0;
            pend_nxt[k] = 1'b0;
         end else if (ev[k].up) begin
            up_go = 1'b1;
         end else if (ev[k].down) begin
            dn_go = 1'b1;
         end
         if (run_r[k] & tick & ~ev[k].preset & ~ev[k].stop & ~up_go & ~dn_go) begin
            up_go = 1'b1;
            s     = 33'h0_0000_0001;
         end
         // pulses ignored after a stop until the next run
         if (halt_r[k]) begin
            up_go = 1'b0;
            dn_go = 1'b0;
         end
         if (~en | ~act | (~ring & (ovf_r | unf_r))) begin
            up_go = 1'b0;
            dn_go = 1'b0;
         end
         v = c;
         if (up_go) begin
            if (~ring & (c + s > hi)) begin
               if (k == 0) ovf_nxt = 1'b1;
            end else if (ring & (c + s >= hi) & (hi != lo)) begin
               v = lo;
            end else begin
               v = c + s;
            end
         end else if (dn_go) begin
            if (~ring & ((c < s) | (c - s < lo))) begin
               if (k == 0) unf_nxt = 1'b1;
            end else if (ring & (c == lo) & (hi != lo)) begin
               v = hi - 33'h0_0000_0001;
            end else begin
               v = c - s;
            end
         end
         if (up_go | dn_go) begin
            v[32] = v[32] ^ sgn;
            cnt_nxt[k] = wide ? v[31:0] : {16'h0000, v[15:0]};
         end
         if (~logic_on) begin
            cnt_nxt[k]  = 32'h0000_0000;
            halt_nxt[k] = 1'b0;
            run_nxt[k]  = 1'b0;
            pend_nxt[k] = 1'b0;
         end
      end
   end

   // register writes
   always_comb begin
      cfg_nxt = cfg_r;
      sw_run  = 2'b00;
      sw_stop = 2'b00;
      for (int k = 0; k < 2; k++) begin
         upper_nxt[k] = upper_r[k];
         lower_nxt[k] = lower_r[k];
         pre_nxt[k]   = pre_r[k];
         step_nxt[k]  = step_r[k];
      end
      if (wr) begin
         unique case (paddr)
            cct_pkg::OFS_CTRL: begin
               sw_run[0]  = pwdata[cct_pkg::CTRL_RUN_BIT];
               sw_stop[0] = pwdata[cct_pkg::CTRL_STOP_BIT];
               sw_run[1]  = pwdata[cct_pkg::CTRL_RUN_BIT + 16];
               sw_stop[1] = pwdata[cct_pkg::CTRL_STOP_BIT + 16];
            end
            cct_pkg::OFS_CFG:     cfg_nxt      = pwdata;
            cct_pkg::OFS_UPPER0:  upper_nxt[0] = pwdata;
            cct_pkg::OFS_LOWER0:  lower_nxt[0] = pwdata;
            cct_pkg::OFS_PRESET0: pre_nxt[0]   = pwdata;
            cct_pkg::OFS_STEP0:   step_nxt[0]  = pwdata;
            cct_pkg::OFS_UPPER1:  upper_nxt[1] = pwdata;
            cct_pkg::OFS_LOWER1:  lower_nxt[1] = pwdata;
            cct_pkg::OFS_PRESET1: pre_nxt[1]   = pwdata;
            cct_pkg::OFS_STEP1:   step_nxt[1]  = pwdata;
            default: ;
         endcase
      end
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
         cct_pkg::OFS_CFG:     prdata_nxt = cfg_r;
         cct_pkg::OFS_UPPER0:  prdata_nxt = upper_r[0];
         cct_pkg::OFS_LOWER0:  prdata_nxt = lower_r[0];
         cct_pkg::OFS_PRESET0: prdata_nxt = pre_r[0];
         cct_pkg::OFS_STEP0:   prdata_nxt = step_r[0];
         cct_pkg::OFS_UPPER1:  prdata_nxt = upper_r[1];
         cct_pkg::OFS_LOWER1:  prdata_nxt = lower_r[1];
         cct_pkg::OFS_PRESET1: prdata_nxt = pre_r[1];
         cct_pkg::OFS_STEP1:   prdata_nxt = step_r[1];
         cct_pkg::OFS_COUNT0:  prdata_nxt = cnt_r[0];
         cct_pkg::OFS_COUNT1:  prdata_nxt = cnt_r[1];
         cct_pkg::OFS_LATCH0:  prdata_nxt = lat_r[0];
         cct_pkg::OFS_LATCH1:  prdata_nxt = lat_r[1];
         cct_pkg::OFS_STATUS:  prdata_nxt = {28'h000_0000, unf_r, ovf_r, run_r};
         default:              prdata_nxt = 32'h0000_0000;
      endcase
   end

   logic unmapped;
   assign unmapped = (paddr > cct_pkg::OFS_STATUS) | (paddr[1:0] != 2'b00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r     <= cct_pkg::CFG_RESET;
         tick_r    <= 16'h0000;
         ovf_r     <= 1'b0;
         unf_r     <= 1'b0;
         run_r     <= 2'b00;
         pend_r    <= 2'b00;
         lvl_r     <= 2'b00;
         halt_r    <= 2'b00;
         prdata    <= 32'h0000_0000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         count_out <= 32'h0000_0000;
         overflow  <= 1'b0;
         underflow <= 1'b0;
         for (int k = 0; k < 2; k++) begin
            upper_r[k] <= LIM_HI16U;
            lower_r[k] <= 32'h0000_0000;
            pre_r[k]   <= 32'h0000_0000;
            step_r[k]  <= 32'h0000_0000;
            cnt_r[k]   <= 32'h0000_0000;
            lat_r[k]   <= 32'h0000_0000;
         end
      end else if (ce) begin
         cfg_r     <= cfg_nxt;
         tick_r    <= tick_nxt;
         ovf_r     <= ovf_nxt;
         unf_r     <= unf_nxt;
         run_r     <= run_nxt;
         pend_r    <= pend_nxt;
         lvl_r     <= lvl_nxt;
         halt_r    <= halt_nxt;
         prdata    <= rd ? prdata_nxt : 32'h0000_0000;
         pready    <= psel & ~penable;
         pslverr   <= psel & ~penable & unmapped;
         count_out <= cnt_nxt[0];
         overflow  <= ovf_nxt;
         underflow <= unf_nxt;
         for (int k = 0; k < 2; k++) begin
            upper_r[k] <= upper_nxt[k];
            lower_r[k] <= lower_nxt[k];
            pre_r[k]   <= pre_nxt[k];
            step_r[k]  <= step_nxt[k];
            cnt_r[k]   <= cnt_nxt[k];
            lat_r[k]   <= lat_nxt[k];
         end
      end
   end

   // assertions
   property p_preset_load;
      @(posedge pclk) disable iff (!presetn)
      (ce & logic_on & ev[0].preset) |=> (cnt_r[0] == $past(pre_r[0]));
   endproperty
   a_preset_load: assert property (p_preset_load) else $error("preset not loaded");

   property p_stop_halts;
      @(posedge pclk) disable iff (!presetn)
      (ce & ~ev[0].preset & ev[0].stop) |=> ~run_r[0];
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("stop did not halt");

   sequence s_preset_run;
      ce & logic_on & ev[0].preset & ev[0].run & ~ev[0].stop & ~cfg_r[cct_pkg::CFG_PS_BIT];
   endsequence
   property p_run_pending;
      @(posedge pclk) disable iff (!presetn)
      s_preset_run ##1 (ce & logic_on & ~ev[0].preset & ~ev[0].stop) |=> run_r[0];
   endproperty
   a_run_pending: assert property (p_run_pending) else $error("pending run lost");

   property p_logic_off;
      @(posedge pclk) disable iff (!presetn)
      (ce & ~logic_on) |=> (cnt_r[0] == 32'h0000_0000) && (cnt_r[1] == 32'h0000_0000);
   endproperty
   a_logic_off: assert property (p_logic_off) else $error("count not cleared");

   property p_disable_freeze;
      @(posedge pclk) disable iff (!presetn)
      (ce & logic_on & ~cfg_r[cct_pkg::CFG_ENABLE_BIT] & ~ev[0].preset & ~ev[0].stop)
         |=> $stable(cnt_r[0]);
   endproperty
   a_disable_freeze: assert property (p_disable_freeze) else $error("count moved while off");

   property p_latch;
      @(posedge pclk) disable iff (!presetn)
      (ce & ev[0].latch) |=> (lat_r[0] == $past(cnt_r[0]));
   endproperty
   a_latch: assert property (p_latch) else $error("latch missed");

   property p_ovf_frozen;
      @(posedge pclk) disable iff (!presetn)
      (ce & logic_on & ovf_r & ~ring & ~ev[0].preset & ~(ev[0].stop & cfg_r[cct_pkg::CFG_SP_BIT]))
         |=> $stable(cnt_r[0]) && ovf_r;
   endproperty
   a_ovf_frozen: assert property (p_ovf_frozen) else $error("count moved after overflow");

   property p_up_one;
      @(posedge pclk) disable iff (!presetn)
      (ce & logic_on & wide & ring & ~stepm & cfg_r[cct_pkg::CFG_ENABLE_BIT] & ~halt_r[0]
       & ev[0].up & ~ev[0].preset & ~ev[0].stop & ~ev[0].run & ~pend_r[0]
       & (cnt_r[0] + 32'h0000_0001 != upper_r[0]) & (upper_r[0] == lower_r[0]))
         |=> (cnt_r[0] == $past(cnt_r[0]) + 32'h0000_0001);
   endproperty
   a_up_one: assert property (p_up_one) else $error("up count wrong");
endmodule : cct_top
`default_nettype wire

/* verification/cct_ev_src.sv */
// cct_ev_src: upstream event logic feeding the counter terminals
// assumes the bench sets one event struct per counter after a pclk edge
`timescale 1ns/10ps
`default_nettype none
module cct_ev_src #(
   parameter int NSRC = 2
) (
   input  wire cct_pkg::cct_ev_type ev        [2],
   input  wire logic                src,
   output logic      [NSRC-1:0]     ev_preset [2],
   output logic      [NSRC-1:0]     ev_stop   [2],
   output logic      [NSRC-1:0]     ev_run    [2],
   output logic      [NSRC-1:0]     ev_up     [2],
   output logic      [NSRC-1:0]     ev_down   [2],
   output logic      [1:0]          latch_ev,
   output logic      [1:0]          latch_lvl
);
   // one source line per terminal, picked by src; the rest stay low
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ev_preset[i] = '0;
         ev_stop[i] = '0;
         ev_run[i] = '0;
         ev_up[i] = '0;
         ev_down[i] = '0;
         ev_preset[i][src] = ev[i].preset;
         ev_stop[i][src] = ev[i].stop;
         ev_run[i][src] = ev[i].run;
         ev_up[i][src] = ev[i].up;
         ev_down[i][src] = ev[i].down;
         latch_ev[i] = ev[i].latch;
         latch_lvl[i] = ev[i].latch_lvl;
      end
   end
endmodule : cct_ev_src
`default_nettype wire

/* verification/configurable_counter_timer_tb.sv */
// configurable_counter_timer_tb: self-checking bench for cct_top
// assumes the event model cct_ev_src and the cct_pkg register map
`timescale 1ns/10ps
`default_nettype none
module configurable_counter_timer_tb;
   localparam logic [6:0] PR = 7'h40, ST = 7'h20, RN = 7'h10, UP = 7'h08;
   localparam logic [6:0] DN = 7'h04, LA = 7'h02, LL = 7'h01;
   logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic                pwrite = 1'b0, src = 1'b0, ce = 1'b1, erf;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h0, prdata, count_out, rd, a, d;
   logic                pready, pslverr, overflow, underflow;
   logic [1:0]          latch_ev, latch_lvl;
   logic [1:0]          ev_preset [2], ev_stop [2], ev_run [2], ev_up [2], ev_down [2];
   cct_pkg::cct_ev_type ev [2] = '{'0, '0};
   int                  fails = 0, total_checks = 0;
   always #25 pclk = ~pclk;
   cct_top #(.NSRC(2)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ev_preset(ev_preset), .ev_stop(ev_stop),
      .ev_run(ev_run), .ev_up(ev_up), .ev_down(ev_down), .latch_ev(latch_ev),
      .latch_lvl(latch_lvl), .count_out(count_out), .overflow(overflow),
      .underflow(underflow));
   cct_ev_src #(.NSRC(2)) src_u (.ev(ev), .src(src), .ev_preset(ev_preset),
      .ev_stop(ev_stop), .ev_run(ev_run), .ev_up(ev_up), .ev_down(ev_down),
      .latch_ev(latch_ev), .latch_lvl(latch_lvl));
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         end_of_test();
      end
      rd = prdata;
      erf = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task wr(input logic [11:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd);
   endtask : wr
   task rdchk(input string nm, input logic [11:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(nm, rd, e);
   endtask : rdchk
   task go(input int c, input logic [6:0] e, input int n);
      ev[c] <= cct_pkg::cct_ev_type'(e);
      repeat (n) @(posedge pclk);
      ev[c] <= '0;
      @(posedge pclk);
   endtask : go
   task smp(output logic [31:0] v);
      @(negedge pclk);
      v = count_out;
      @(posedge pclk);
   endtask : smp
   task cc(input logic [31:0] e);
      smp(a);
      chk("count", a, e);
   endtask : cc
   task gap(input int k, output logic [31:0] dv);
      logic [31:0] b;
      smp(b);
      repeat (k - 1) @(posedge pclk);
      smp(dv);
      dv = dv - b;
   endtask : gap
   task t_defaults;
      rdchk("cfg", cct_pkg::OFS_CFG, cct_pkg::CFG_RESET);
      rdchk("upper", cct_pkg::OFS_UPPER0, 32'h0000_FFFF);
      rdchk("lower", cct_pkg::OFS_LOWER0, 32'h0000_0000);
      rdchk("preset", cct_pkg::OFS_PRESET0, 32'h0000_0000);
      apb(1'b0, 12'h03C, 32'h0);
      chk("slverr", erf, 32'h1);
      chk("unmapped", rd, 32'h0);
      $display("test defaults done");
   endtask : t_defaults
   task t_pulse;
      go(0, UP, 1);
      cc(32'h1);
      go(0, UP, 3);
      cc(32'h4);
      go(0, DN, 1);
      cc(32'h3);
      go(0, UP | DN, 1);
      cc(32'h4);
      src <= 1'b1;
      go(0, UP, 1);
      cc(32'h5);
      src <= 1'b0;
      go(1, UP, 2);
      rdchk("count1", cct_pkg::OFS_COUNT1, 32'h2);
      cc(32'h5);
      wr(cct_pkg::OFS_STEP0, 32'h5);
      wr(cct_pkg::OFS_CFG, 32'h0000_012C);
      go(0, UP, 1);
      cc(32'hA);
      go(0, LA, 1);
      rdchk("latch", cct_pkg::OFS_LATCH0, 32'hA);
      go(0, DN, 2);
      cc(32'h0);
      go(0, LL, 2);
      rdchk("latch", cct_pkg::OFS_LATCH0, 32'h0);
      wr(cct_pkg::OFS_CFG, cct_pkg::CFG_RESET);
      $display("test pulse done");
   endtask : t_pulse
   task t_run;
      go(0, RN, 1);
      gap(8, d);
      chk("ticks", d, 32'h8);
      go(0, ST, 3);
      gap(5, d);
      chk("stopped", d, 32'h0);
      smp(a);
      go(0, UP, 1);
      cc(a);
      go(0, ST | RN, 1);
      gap(5, d);
      chk("stop wins", d, 32'h0);
      wr(cct_pkg::OFS_CTRL, 32'h1);
      rdchk("status", cct_pkg::OFS_STATUS, 32'h1);
      gap(4, d);
      chk("sw run", d, 32'h4);
      wr(cct_pkg::OFS_CFG, 32'h0000_0108);
      gap(5, d);
      chk("disabled", d, 32'h0);
      wr(cct_pkg::OFS_CTRL, 32'h2);
      rdchk("status", cct_pkg::OFS_STATUS, 32'h0);
      wr(cct_pkg::OFS_CFG, 32'h0000_000C);
      cc(32'h0);
      wr(cct_pkg::OFS_CFG, 32'h0000_310C);
      wr(cct_pkg::OFS_CTRL, 32'h1);
      gap(40, d);
      chk("1us ticks", d, 32'h2);
      wr(cct_pkg::OFS_CTRL, 32'h2);
      $display("test run done");
   endtask : t_run
   task t_preset;
      wr(cct_pkg::OFS_CFG, cct_pkg::CFG_RESET);
      wr(cct_pkg::OFS_PRESET0, 32'd100);
      ev[0] <= cct_pkg::cct_ev_type'(PR | RN);
      @(posedge pclk);
      ev[0] <= '0;
      cc(32'd100);
      gap(5, d);
      chk("run after preset", d, 32'h5);
      wr(cct_pkg::OFS_CFG, 32'h0000_014C);
      go(0, ST, 1);
      cc(32'd100);
      wr(cct_pkg::OFS_CFG, 32'h0000_018C);
      go(0, RN, 3);
      go(0, PR, 1);
      gap(5, d);
      chk("preset stops", d, 32'h0);
      cc(32'd100);
      $display("test preset done");
   endtask : t_preset
   task t_linear;
      wr(cct_pkg::OFS_CFG, 32'h0000_010D);
      wr(cct_pkg::OFS_UPPER0, 32'h0001_0001);
      wr(cct_pkg::OFS_PRESET0, 32'h0000_FFFF);
      go(0, PR, 1);
      go(0, UP, 1);
      cc(32'h0001_0000);
      go(0, UP, 1);
      go(0, UP, 1);
      cc(32'h0001_0001);
      chk("ovf", overflow, 32'h1);
      go(0, PR, 1);
      chk("ovf clr", overflow, 32'h0);
      cc(32'h0000_FFFF);
      wr(cct_pkg::OFS_LOWER0, 32'h0000_FFFF);
      go(0, DN, 1);
      cc(32'h0000_FFFF);
      chk("unf", underflow, 32'h1);
      rdchk("status", cct_pkg::OFS_STATUS, 32'h8);
      $display("test linear done");
   endtask : t_linear
   task t_ring;
      wr(cct_pkg::OFS_CFG, 32'h0000_011F);
      wr(cct_pkg::OFS_UPPER0, 32'h0000_0000);
      wr(cct_pkg::OFS_LOWER0, 32'h0000_0000);
      wr(cct_pkg::OFS_PRESET0, 32'h7FFF_FFFF);
      go(0, PR, 1);
      go(0, UP, 1);
      cc(32'h8000_0000);
      go(0, DN, 1);
      cc(32'h7FFF_FFFF);
      wr(cct_pkg::OFS_CFG, cct_pkg::CFG_RESET);
      wr(cct_pkg::OFS_UPPER0, 32'h0000_0003);
      wr(cct_pkg::OFS_PRESET0, 32'h0000_0002);
      go(0, PR, 1);
      go(0, UP, 1);
      cc(32'h0000_0000);
      ce <= 1'b0;
      go(0, UP, 2);
      ce <= 1'b1;
      cc(32'h0000_0000);
      $display("test ring done");
   endtask : t_ring
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_defaults();
      t_pulse();
      t_run();
      t_preset();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_linear();
      t_ring();
      end_of_test();
   end
endmodule : configurable_counter_timer_tb
`default_nettype wire
